// ### fcs_consts.svh
// Purpose: Named offsets, field positions, codes and reset values of the FPU control registers
// Assumes: Included by its bare name from every design file that needs it
// Notes: Definitions only
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// ==========================================================
// Coprocessor register numbers
`define FCS_REG_MODES 5'h1c
`define FCS_REG_FULL 5'h1f

// ==========================================================
// Full control/status view field positions
`define FCS_CC_HI_MSB 31
`define FCS_CC_HI_LSB 25
`define FCS_FLUSH_DEN 24
`define FCS_CC_LO 23
`define FCS_OVERRIDE 22
`define FCS_NEAR_FLUSH 21
`define FCS_MAC 20
`define FCS_ABS 19
`define FCS_NAN 18
`define FCS_CAUSE_MSB 17
`define FCS_CAUSE_LSB 12
`define FCS_CAUSE_UNIMPL 5
`define FCS_EN_MSB 11
`define FCS_EN_LSB 7
`define FCS_FLAG_MSB 6
`define FCS_FLAG_LSB 2
`define FCS_ROUND_MSB 1
`define FCS_ROUND_LSB 0

// ==========================================================
// Enables-and-modes view field positions
`define FCS_FLUSH_DEN_VIEW 2

// ==========================================================
// Fixed mode values
`define FCS_MAC_VAL 1'b0
`define FCS_ABS_VAL 1'b1
`define FCS_NAN_VAL 1'b1

// ==========================================================
// Rounding mode codes
`define FCS_ROUND_NEAREST 2'h0
`define FCS_ROUND_ZERO 2'h1
`define FCS_ROUND_PLUS 2'h2
`define FCS_ROUND_MINUS 2'h3

// ==========================================================
// Reset values
`define FCS_RST_ROUND 2'h0
`define FCS_RST_BIT 1'b0
`define FCS_RST_EN 5'h00
`define FCS_RST_CAUSE 6'h00
`define FCS_RST_FLAGS 5'h00
`define FCS_RST_CC 8'h00
`define FCS_RST_WORD 32'h0000_0000

`endif

// ### fcs_pkg.sv
// Purpose: Types shared by the FPU control register bank
// Assumes: Field layouts of fcs_consts.svh
// Notes: Exception vectors are ordered invalid, divide-by-zero, overflow, underflow, inexact
package fcs_pkg;

   // ==========================================================
   // Tiny result handling chosen by the flush controls
   typedef enum logic [1:0] {
      FCS_TINY_GRADUAL,
      FCS_TINY_KEEP,
      FCS_TINY_FLUSH_DIR,
      FCS_TINY_NEAREST
   } fcs_tiny_type;

   // ==========================================================
   // Reports from the arithmetic datapath
   typedef struct packed {
      logic done;
      logic [4:0] cause;
      logic denorm_in;
   } fcs_dp_report_type;

   typedef struct packed {
      logic valid;
      logic [2:0] index;
      logic result;
   } fcs_cmp_report_type;

   // ==========================================================
   // Whole state of the register bank
   typedef struct packed {
      logic [1:0] rounding_mode;
      logic flush_denormals;
      logic flush_override;
      logic flush_to_nearest;
      logic fused_multiply_add_mode;
      logic ieee_abs_negate_mode;
      logic ieee_nan_encoding;
      logic [4:0] enables;
      logic [5:0] cause;
      logic [4:0] flags;
      logic [7:0] cc;
      logic trap;
      logic [31:0] rdata;
      logic rvalid;
      fcs_tiny_type tiny;
      logic tiny_pos_smallest_normal_value;
      logic tiny_neg_smallest_normal_value;
      logic denorm_flush;
   } fcs_state_type;

endpackage : fcs_pkg

// ### fcs_trap_check.sv
// Purpose: Detects an enabled exception cause
// Assumes: Enable and cause vectors in the same bit order
// Notes: Purely combinational
`timescale 1ns/1ns
module fcs_trap_check #(
   parameter int N = 5
) (
   input wire logic [N-1:0] enables,
   input wire logic [N-1:0] cause,
   output logic hit
);

   // ==========================================================
   // Match
   assign hit = |(enables & cause);

endmodule : fcs_trap_check

// ### fcs_tiny_policy.sv
// Purpose: Decodes flush and rounding controls into datapath handling of tiny values
// Assumes: Inputs are the register values about to be stored
// Notes: Purely combinational; the caller registers the results
`timescale 1ns/1ns
`include "fcs_consts.svh"
module fcs_tiny_policy (
   input wire logic [1:0] rounding_mode,
   input wire logic flush_denormals,
   input wire logic flush_override,
   input wire logic flush_to_nearest,
   output fcs_pkg::fcs_tiny_type tiny,
   output logic pos_smallest_normal_value,
   output logic neg_smallest_normal_value,
   output logic denorm_flush
);

   // ==========================================================
   // Policy decode
   always_comb begin
      if (flush_override) begin
         tiny = fcs_pkg::FCS_TINY_KEEP;
      end else if (flush_to_nearest && rounding_mode == `FCS_ROUND_NEAREST) begin
         tiny = fcs_pkg::FCS_TINY_NEAREST;
      end else if (flush_denormals || flush_to_nearest) begin
         tiny = fcs_pkg::FCS_TINY_FLUSH_DIR;
      end else begin
         tiny = fcs_pkg::FCS_TINY_GRADUAL;
      end
   end

   // Directed flush: toward the infinity of the sign picks the smallest normal
   assign pos_smallest_normal_value = (tiny == fcs_pkg::FCS_TINY_FLUSH_DIR)
      && (rounding_mode == `FCS_ROUND_PLUS);
   assign neg_smallest_normal_value = (tiny == fcs_pkg::FCS_TINY_FLUSH_DIR)
      && (rounding_mode == `FCS_ROUND_MINUS);
   assign denorm_flush = flush_denormals;

endmodule : fcs_tiny_policy

// ### fcs_regs.sv
// Purpose: Control and status register bank of the floating point coprocessor
// Assumes: Core moves are one-cycle strobes; datapath reports are one-cycle pulses on mclk
// Notes: Read data is registered and appears one cycle after the read strobe
`timescale 1ns/1ns
`include "fcs_consts.svh"

// Behaviour
// - Trap when any exception enable bit and its matching cause bit are set.
// - Trap check runs after datapath cause updates and after register writes.
// - Enables sit at bits 11..7: invalid, divzero, overflow, underflow, inexact.
// - Flush-to-zero on: denormal inputs become zero, tiny results flush by rounding.
// - Flush-to-zero off: denormal input raises the unimplemented operation cause.
// - Rounding field bits 1:0: 00 nearest, 01 zero, 10 plus, 11 minus.
// - Flush override on: keep unbounded exponent, no forcing, no exception.
// - With override and nearest-flush off, tiny handling follows flush-to-zero.
// - Nearest-flush under nearest rounding picks closer of zero or smallest normal.
// - Fused multiply-add mode bit reads zero; multiply-add is unfused.
// - Absolute/negate format bit reads one; quiet NaN inputs never trap.
// - NaN encoding bit reads one: quiet NaN has fraction top bit set.
// - Cause bits 17..12 record the current instruction's exceptions.
// - Sticky flags bits 6..2 accumulate exceptions until software clears them.
// - Eight compare condition codes live at bits 31..25 and bit 23.
// - Enables-and-modes view reads zero at bits 31..12 and 6..3.
module fcs_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cp_wr,
   input wire logic [4:0] cp_wsel,
   input wire logic [31:0] cp_wdata,
   input wire logic cp_rd,
   input wire logic [4:0] cp_rsel,
   output logic [31:0] cp_rdata_r,
   output logic cp_rvalid_r,
   input wire fcs_pkg::fcs_dp_report_type dp_report,
   input wire fcs_pkg::fcs_cmp_report_type cmp_report,
   output logic [1:0] rounding_mode_r,
   output logic flush_denormals_r,
   output logic flush_override_r,
   output logic flush_to_nearest_r,
   output logic fused_multiply_add_mode_r,
   output logic ieee_abs_negate_mode_r,
   output logic ieee_nan_encoding_r,
   output logic denorm_flush_r,
   output fcs_pkg::fcs_tiny_type tiny_policy_r,
   output logic tiny_pos_smallest_normal_value_r,
   output logic tiny_neg_smallest_normal_value_r,
   output logic [7:0] compare_condition_codes_r,
   output logic [4:0] exception_cause_r,
   output logic fp_trap_r
);

   // ==========================================================
   // State and decode
   fcs_pkg::fcs_state_type st_r;
   fcs_pkg::fcs_state_type st_nxt;
   logic wr_full;
   logic wr_view;
   logic [1:0] round_next;
   logic flush_den_next;
   logic override_next;
   logic near_flush_next;
   logic [4:0] en_next;
   logic [5:0] cause_wr;
   logic [5:0] cause_next;
   logic [4:0] flags_wr;
   logic [4:0] flags_next;
   logic trap_hit;
   fcs_pkg::fcs_tiny_type tiny_next;
   logic pos_mn_next;
   logic neg_mn_next;
   logic dflush_next;

   assign wr_full = cp_wr && (cp_wsel == `FCS_REG_FULL);
   assign wr_view = cp_wr && (cp_wsel == `FCS_REG_MODES);

   // ==========================================================
   // Views of the shared storage
   function automatic logic [31:0] full_view(input fcs_pkg::fcs_state_type s);
      logic [31:0] v;
      v = `FCS_RST_WORD;
      v[`FCS_CC_HI_MSB:`FCS_CC_HI_LSB] = s.cc[7:1];
      v[`FCS_FLUSH_DEN] = s.flush_denormals;
      v[`FCS_CC_LO] = s.cc[0];
      v[`FCS_OVERRIDE] = s.flush_override;
      v[`FCS_NEAR_FLUSH] = s.flush_to_nearest;
      v[`FCS_MAC] = s.fused_multiply_add_mode;
      v[`FCS_ABS] = s.ieee_abs_negate_mode;
      v[`FCS_NAN] = s.ieee_nan_encoding;
      v[`FCS_CAUSE_MSB:`FCS_CAUSE_LSB] = s.cause;
      v[`FCS_EN_MSB:`FCS_EN_LSB] = s.enables;
      v[`FCS_FLAG_MSB:`FCS_FLAG_LSB] = s.flags;
      v[`FCS_ROUND_MSB:`FCS_ROUND_LSB] = s.rounding_mode;
      return v;
   endfunction : full_view

   // Unused positions stay at the cleared start value
   function automatic logic [31:0] modes_view(input fcs_pkg::fcs_state_type s);
      logic [31:0] v;
      v = `FCS_RST_WORD;
      v[`FCS_EN_MSB:`FCS_EN_LSB] = s.enables;
      v[`FCS_FLUSH_DEN_VIEW] = s.flush_denormals;
      v[`FCS_ROUND_MSB:`FCS_ROUND_LSB] = s.rounding_mode;
      return v;
   endfunction : modes_view

   // ==========================================================
   // Next values of the writable fields
   // The modes view writes only rounding, flush-to-zero and enables; both views read these back alike
   assign round_next = (wr_full || wr_view) ? cp_wdata[`FCS_ROUND_MSB:`FCS_ROUND_LSB]
                                            : st_r.rounding_mode;
   assign flush_den_next = wr_full ? cp_wdata[`FCS_FLUSH_DEN]
      : wr_view ? cp_wdata[`FCS_FLUSH_DEN_VIEW]
      : st_r.flush_denormals;
   assign override_next = wr_full ? cp_wdata[`FCS_OVERRIDE] : st_r.flush_override;
   assign near_flush_next = wr_full ? cp_wdata[`FCS_NEAR_FLUSH] : st_r.flush_to_nearest;
   assign en_next = (wr_full || wr_view) ? cp_wdata[`FCS_EN_MSB:`FCS_EN_LSB]
                                         : st_r.enables;

   // A datapath cause arriving with a write is merged, not lost
   assign cause_wr = wr_full ? cp_wdata[`FCS_CAUSE_MSB:`FCS_CAUSE_LSB] : `FCS_RST_CAUSE;
   always_comb begin
      cause_next = st_r.cause;
      if (wr_full) begin
         cause_next = cause_wr;
      end
      if (dp_report.done) begin
         cause_next = cause_wr | {1'b0, dp_report.cause};
         // Denormal input without flushing is left to software
         cause_next[`FCS_CAUSE_UNIMPL] = cause_wr[`FCS_CAUSE_UNIMPL]
            | (dp_report.denorm_in & ~st_r.flush_denormals);
      end
   end

   // Set wins over a clearing write in the same cycle
   assign flags_wr = wr_full ? cp_wdata[`FCS_FLAG_MSB:`FCS_FLAG_LSB] : st_r.flags;
   assign flags_next = dp_report.done ? (flags_wr | dp_report.cause) : flags_wr;

   // ==========================================================
   // Trap detect and tiny value policy
   fcs_trap_check #(
      .N(5)
   ) u_trap (
      .enables(en_next),
      .cause(cause_next[4:0]),
      .hit(trap_hit)
   );

   fcs_tiny_policy u_tiny (
      .rounding_mode(round_next),
      .flush_denormals(flush_den_next),
      .flush_override(override_next),
      .flush_to_nearest(near_flush_next),
      .tiny(tiny_next),
      .pos_smallest_normal_value(pos_mn_next),
      .neg_smallest_normal_value(neg_mn_next),
      .denorm_flush(dflush_next)
   );

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rounding_mode = round_next;
      st_nxt.flush_denormals = flush_den_next;
      st_nxt.flush_override = override_next;
      st_nxt.flush_to_nearest = near_flush_next;
      st_nxt.enables = en_next;
      st_nxt.cause = cause_next;
      st_nxt.flags = flags_next;
      st_nxt.tiny = tiny_next;
      st_nxt.tiny_pos_smallest_normal_value = pos_mn_next;
      st_nxt.tiny_neg_smallest_normal_value = neg_mn_next;
      st_nxt.denorm_flush = dflush_next;
      // Trap is a pulse: only a fresh cause or a fresh write requests it
      st_nxt.trap = (wr_full || wr_view || dp_report.done) && trap_hit;
      if (wr_full) begin
         st_nxt.cc[7:1] = cp_wdata[`FCS_CC_HI_MSB:`FCS_CC_HI_LSB];
         st_nxt.cc[0] = cp_wdata[`FCS_CC_LO];
      end
      // Compare result beats a write to the same code bit
      if (cmp_report.valid) begin
         st_nxt.cc[cmp_report.index] = cmp_report.result;
      end
      st_nxt.rvalid = cp_rd;
      st_nxt.rdata = `FCS_RST_WORD;
      if (cp_rd) begin
         case (cp_rsel)
            `FCS_REG_FULL: begin
               st_nxt.rdata = full_view(st_r);
            end
            `FCS_REG_MODES: begin
               st_nxt.rdata = modes_view(st_r);
            end
            default: begin
               st_nxt.rdata = `FCS_RST_WORD;
            end
         endcase
      end
   end

   // ==========================================================
   // Register
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r.rounding_mode <= `FCS_RST_ROUND;
         st_r.flush_denormals <= `FCS_RST_BIT;
         st_r.flush_override <= `FCS_RST_BIT;
         st_r.flush_to_nearest <= `FCS_RST_BIT;
         st_r.fused_multiply_add_mode <= `FCS_MAC_VAL;
         st_r.ieee_abs_negate_mode <= `FCS_ABS_VAL;
         st_r.ieee_nan_encoding <= `FCS_NAN_VAL;
         st_r.enables <= `FCS_RST_EN;
         st_r.cause <= `FCS_RST_CAUSE;
         st_r.flags <= `FCS_RST_FLAGS;
         st_r.cc <= `FCS_RST_CC;
         st_r.trap <= `FCS_RST_BIT;
         st_r.rdata <= `FCS_RST_WORD;
         st_r.rvalid <= `FCS_RST_BIT;
         st_r.tiny <= fcs_pkg::FCS_TINY_GRADUAL;
         st_r.tiny_pos_smallest_normal_value <= `FCS_RST_BIT;
         st_r.tiny_neg_smallest_normal_value <= `FCS_RST_BIT;
         st_r.denorm_flush <= `FCS_RST_BIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign cp_rdata_r = st_r.rdata;
   assign cp_rvalid_r = st_r.rvalid;
   assign rounding_mode_r = st_r.rounding_mode;
   assign flush_denormals_r = st_r.flush_denormals;
   assign flush_override_r = st_r.flush_override;
   assign flush_to_nearest_r = st_r.flush_to_nearest;
   assign fused_multiply_add_mode_r = st_r.fused_multiply_add_mode;
   assign ieee_abs_negate_mode_r = st_r.ieee_abs_negate_mode;
   assign ieee_nan_encoding_r = st_r.ieee_nan_encoding;
   assign denorm_flush_r = st_r.denorm_flush;
   assign tiny_policy_r = st_r.tiny;
   assign tiny_pos_smallest_normal_value_r = st_r.tiny_pos_smallest_normal_value;
   assign tiny_neg_smallest_normal_value_r = st_r.tiny_neg_smallest_normal_value;
   assign compare_condition_codes_r = st_r.cc;
   assign exception_cause_r = st_r.cause[4:0];
   assign fp_trap_r = st_r.trap;

   // ==========================================================
   // Assertions
   a_trap_has_cause: assert property (@(posedge mclk) disable iff (rst)
      st_r.trap |-> |(st_r.enables & st_r.cause[4:0]))
      else $error("trap without enabled cause");

   a_trap_on_write: assert property (@(posedge mclk) disable iff (rst)
      (wr_full && |(cp_wdata[`FCS_EN_MSB:`FCS_EN_LSB] & cp_wdata[16:12])) |=> st_r.trap)
      else $error("write with enabled cause did not trap");

   a_trap_on_dp: assert property (@(posedge mclk) disable iff (rst)
      (dp_report.done && !cp_wr && |(st_r.enables & dp_report.cause)) |=> st_r.trap)
      else $error("datapath cause did not trap");

   a_cause_record: assert property (@(posedge mclk) disable iff (rst)
      (dp_report.done && !cp_wr) |=> st_r.cause[4:0] == $past(dp_report.cause))
      else $error("cause not recorded");

   a_unimpl_denorm: assert property (@(posedge mclk) disable iff (rst)
      (dp_report.done && !cp_wr && dp_report.denorm_in && !st_r.flush_denormals)
      |=> st_r.cause[`FCS_CAUSE_UNIMPL])
      else $error("denormal input did not raise unimplemented cause");

   a_flags_sticky: assert property (@(posedge mclk) disable iff (rst)
      !wr_full |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
      else $error("sticky flag lost without write");

   a_fixed_bits: assert property (@(posedge mclk) disable iff (rst)
      (cp_rd && cp_rsel == `FCS_REG_FULL)
      |=> cp_rvalid_r && cp_rdata_r[`FCS_MAC:`FCS_NAN] == 3'h3)
      else $error("fixed mode bits wrong");

   a_view_zeros: assert property (@(posedge mclk) disable iff (rst)
      (cp_rd && cp_rsel == `FCS_REG_MODES)
      |=> cp_rdata_r[31:12] == 20'h00000 && cp_rdata_r[6:3] == 4'h0)
      else $error("reserved view bits not zero");

   a_alias_view: assert property (@(posedge mclk) disable iff (rst)
      (wr_view ##1 !cp_wr ##1 (!cp_wr && cp_rd && cp_rsel == `FCS_REG_FULL))
      |=> cp_rdata_r[`FCS_EN_MSB:`FCS_EN_LSB] == $past(cp_wdata[`FCS_EN_MSB:`FCS_EN_LSB], 3))
      else $error("alias view not shared");

   a_rm_written: assert property (@(posedge mclk) disable iff (rst)
      wr_full |=> rounding_mode_r == $past(cp_wdata[`FCS_ROUND_MSB:`FCS_ROUND_LSB]))
      else $error("rounding mode not stored");

   a_cc_capture: assert property (@(posedge mclk) disable iff (rst)
      cmp_report.valid |=> st_r.cc[$past(cmp_report.index)] == $past(cmp_report.result))
      else $error("compare code not captured");

   a_override_keep: assert property (@(posedge mclk) disable iff (rst)
      st_r.flush_override |-> st_r.tiny == fcs_pkg::FCS_TINY_KEEP)
      else $error("override not applied");

   a_nearest_flush: assert property (@(posedge mclk) disable iff (rst)
      (!st_r.flush_override && st_r.flush_to_nearest && st_r.rounding_mode != `FCS_ROUND_NEAREST)
      |-> st_r.tiny == fcs_pkg::FCS_TINY_FLUSH_DIR)
      else $error("nearest flush not directed under other rounding");

   a_denorm_flush: assert property (@(posedge mclk) disable iff (rst)
      wr_full |=> denorm_flush_r == $past(cp_wdata[`FCS_FLUSH_DEN]))
      else $error("denormal flush control not stored");

   c_trap_dp: cover property (@(posedge mclk) disable iff (rst)
      dp_report.done ##1 st_r.trap);
   c_trap_wr: cover property (@(posedge mclk) disable iff (rst)
      wr_view ##1 st_r.trap);
   c_alias: cover property (@(posedge mclk) disable iff (rst)
      wr_view ##2 (cp_rd && cp_rsel == `FCS_REG_FULL));
   c_nearest: cover property (@(posedge mclk) disable iff (rst)
      st_r.tiny == fcs_pkg::FCS_TINY_NEAREST);

endmodule : fcs_regs

// ### fcs_core_dp_model.sv
// Purpose: Far-side model of the arithmetic datapath feeding the register bank
// Assumes: Commands from the bench arrive one cycle ahead of the reports
// Notes: Report data is scrambled whenever the qualifying pulse is low
`timescale 1ns/1ns
module fcs_core_dp_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic dgo,
   input wire logic [4:0] dcause,
   input wire logic dden,
   input wire logic cgo,
   input wire logic [2:0] cidx,
   input wire logic cres,
   output fcs_pkg::fcs_dp_report_type dp_report,
   output fcs_pkg::fcs_cmp_report_type cmp_report
);
   // ==========================================================
   // Report pulses
   // Idle data inverts each cycle so a bank that ignores the pulse shows it
   always_ff @(posedge mclk) begin
      if (rst) begin
         dp_report <= '0;
         cmp_report <= '0;
      end else begin
         dp_report.done <= dgo;
         dp_report.cause <= dgo ? dcause : ~dp_report.cause;
         dp_report.denorm_in <= dgo ? dden : ~dp_report.denorm_in;
         cmp_report.valid <= cgo;
         cmp_report.index <= cgo ? cidx : ~cmp_report.index;
         cmp_report.result <= cgo ? cres : ~cmp_report.result;
      end
   end
endmodule : fcs_core_dp_model

// ### tb_top.sv
// Purpose: Self-checking bench of the FPU control register bank
// Assumes: Reads answer one cycle after the strobe, reports one cycle after the pulse
// Notes: A shadow word mirrors the full control/status view
`timescale 1ns/1ns
`include "fcs_consts.svh"
module tb_top;
   logic mclk, rst, cp_wr, cp_rd, cp_rvalid_r, dgo, dden, cgo, cres, fp_trap_r;
   logic [4:0] cp_wsel, cp_rsel, dcause, exception_cause_r;
   logic [2:0] cidx;
   logic [31:0] cp_wdata, cp_rdata_r, full, w;
   logic [1:0] rounding_mode_r;
   logic flush_denormals_r, flush_override_r, flush_to_nearest_r, denorm_flush_r;
   logic fused_multiply_add_mode_r, ieee_abs_negate_mode_r, ieee_nan_encoding_r;
   logic tiny_pos_smallest_normal_value_r, tiny_neg_smallest_normal_value_r;
   logic [7:0] compare_condition_codes_r;
   fcs_pkg::fcs_tiny_type tiny_policy_r;
   fcs_pkg::fcs_dp_report_type dp_report;
   fcs_pkg::fcs_cmp_report_type cmp_report;
   logic [31:0] rdq[$];
   int num_errors = 0;
   int comparisons = 0;

   fcs_regs dut (.mclk, .rst, .cp_wr, .cp_wsel, .cp_wdata, .cp_rd, .cp_rsel, .cp_rdata_r,
      .cp_rvalid_r, .dp_report, .cmp_report, .rounding_mode_r, .flush_denormals_r,
      .flush_override_r, .flush_to_nearest_r, .fused_multiply_add_mode_r,
      .ieee_abs_negate_mode_r, .ieee_nan_encoding_r, .denorm_flush_r, .tiny_policy_r,
      .tiny_pos_smallest_normal_value_r, .tiny_neg_smallest_normal_value_r, .compare_condition_codes_r,
      .exception_cause_r, .fp_trap_r);
   fcs_core_dp_model far_end (.mclk, .rst, .dgo, .dcause, .dden, .cgo, .cidx, .cres,
      .dp_report, .cmp_report);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ==========================================================
   // Checking
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   always @(posedge mclk) begin
      if (cp_rvalid_r === 1'b1) begin
         if (rdq.size() == 0) check("read surplus", 32'h1, 32'h0);
         else check("read data", rdq.pop_front(), cp_rdata_r);
      end
   end

   function automatic logic [31:0] v28();
      return {20'h0, full[11:7], 4'h0, full[24], full[1:0]};
   endfunction : v28

   task automatic chk_ctl();
      logic [1:0] rmode;
      logic [1:0] tp;
      rmode = full[1:0];
      tp = {full[24], 1'b0};
      if (full[21]) tp = (rmode == `FCS_ROUND_NEAREST) ? 2'h3 : 2'h2;
      if (full[22]) tp = 2'h1;
      check("rounding", {30'h0, rmode}, {30'h0, rounding_mode_r});
      check("flush bits", {29'h0, full[24], full[22:21]},
         {29'h0, flush_denormals_r, flush_override_r, flush_to_nearest_r});
      check("fixed modes", 32'h3, {29'h0, fused_multiply_add_mode_r, ieee_abs_negate_mode_r,
         ieee_nan_encoding_r});
      check("tiny policy", {30'h0, tp}, {30'h0, tiny_policy_r});
      check("smallest_normal_value", {30'h0, tp == 2'h2 && rmode == `FCS_ROUND_PLUS,
         tp == 2'h2 && rmode == `FCS_ROUND_MINUS},
         {30'h0, tiny_pos_smallest_normal_value_r, tiny_neg_smallest_normal_value_r});
      if (full[22:21] == 2'h0) check("denorm flush", {31'h0, full[24]},
         {31'h0, denorm_flush_r});
      check("cond codes", {24'h0, full[31:25], full[23]},
         {24'h0, compare_condition_codes_r});
   endtask : chk_ctl

   // ==========================================================
   // Core register moves
   task automatic wr(input logic [4:0] sel, input logic [31:0] d);
      logic t;
      t = 1'b0;
      if (sel == `FCS_REG_FULL) full = (d & ~32'h001c_0000) | 32'h000c_0000;
      if (sel == `FCS_REG_MODES) begin
         full = {full[31:25], d[2], full[23:12], d[11:7], full[6:2], d[1:0]};
      end
      if (sel == `FCS_REG_FULL || sel == `FCS_REG_MODES) t = |(full[11:7] & full[16:12]);
      @(posedge mclk);
      cp_wr <= 1'b1;
      cp_wsel <= sel;
      cp_wdata <= d;
      @(posedge mclk);
      cp_wr <= 1'b0;
      #1;
      check("trap on write", {31'h0, t}, {31'h0, fp_trap_r});
      chk_ctl();
   endtask : wr

   task automatic rd(input logic [4:0] sel, input logic [31:0] e);
      @(posedge mclk);
      cp_rd <= 1'b1;
      cp_rsel <= sel;
      rdq.push_back(e);
      @(posedge mclk);
      cp_rd <= 1'b0;
   endtask : rd

   // ==========================================================
   // Datapath reports
   task automatic dp(input logic [4:0] c, input logic d);
      logic t;
      full[17:12] = {d & ~full[24], c};
      full[6:2] = full[6:2] | c;
      t = |(full[11:7] & c);
      @(posedge mclk);
      dgo <= 1'b1;
      dcause <= c;
      dden <= d;
      @(posedge mclk);
      dgo <= 1'b0;
      @(posedge mclk);
      #1;
      check("cause", {27'h0, c}, {27'h0, exception_cause_r});
      check("trap on done", {31'h0, t}, {31'h0, fp_trap_r});
      rd(`FCS_REG_FULL, full);
   endtask : dp

   task automatic cmp(input logic [2:0] i, input logic r);
      if (i == 3'h0) full[23] = r;
      else full[24 + i] = r;
      @(posedge mclk);
      cgo <= 1'b1;
      cidx <= i;
      cres <= r;
      @(posedge mclk);
      cgo <= 1'b0;
      @(posedge mclk);
      #1;
      chk_ctl();
   endtask : cmp

   // ==========================================================
   // Tests
   initial begin
      repeat (6000) @(posedge mclk);
      num_errors++;
      summarize();
   end

   initial begin
      {rst, cp_wr, cp_rd, dgo, dden, cgo, cres} = 7'h40;
      {cp_wsel, cp_rsel, dcause, cidx, cp_wdata} = '0;
      full = 32'h000c_0000;
      void'($urandom(32'hf5ce));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk_ctl();
      rd(`FCS_REG_FULL, full);
      rd(`FCS_REG_MODES, 32'h0);
      rd(5'h1d, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 40; k++) begin
         wr(k[0] ? `FCS_REG_FULL : `FCS_REG_MODES, $urandom);
         rd(`FCS_REG_FULL, full);
         rd(`FCS_REG_MODES, v28());
      end
      wr(5'h1a, 32'hffff_ffff);
      rd(`FCS_REG_FULL, full);
      $display("test views done");
      for (int k = 0; k < 32; k++) begin
         w = '0;
         {w[24], w[22], w[21], w[1:0]} = k[4:0];
         wr(`FCS_REG_FULL, w);
      end
      $display("test modes done");
      wr(`FCS_REG_FULL, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(`FCS_REG_MODES, 32'h1 << (7 + i));
         dp(5'h1 << i, 1'b0);
         dp(5'h1 << ((i + 1) % 5), 1'b0);
      end
      wr(`FCS_REG_MODES, 32'h0);
      dp(5'h0, 1'b1);
      wr(`FCS_REG_MODES, 32'h4);
      dp(5'h0, 1'b1);
      for (int k = 0; k < 8; k++) begin
         wr(`FCS_REG_MODES, $urandom);
         dp(5'($urandom), 1'($urandom));
      end
      wr(`FCS_REG_FULL, 32'h0);
      rd(`FCS_REG_FULL, full);
      $display("test exceptions done");
      for (int i = 0; i < 8; i++) cmp(3'(i), 1'b1);
      cmp(3'h3, 1'b0);
      rd(`FCS_REG_FULL, full);
      rd(`FCS_REG_MODES, v28());
      repeat (3) @(posedge mclk);
      check("reads pending", 32'h0, 32'(rdq.size()));
      $display("test compares done");
      summarize();
   end
endmodule : tb_top
